// File: spread_nvm_pkg.sv
// constants for the spread-spectrum and nonvolatile store control bank
// assumes a byte-wide register port decoded by an smbus front end
`default_nettype none
package spread_nvm_pkg;
  localparam logic [7:0] SPREAD_LOCK_OFS = 8'h19;
  localparam logic [7:0] STORE_LEN_OFS = 8'h1a;
  localparam logic [7:0] BUSY_OFS = 8'h18;
  localparam int RATE_LSB = 0;
  localparam int AMOUNT_LSB = 4;
  localparam int LOCK_BIT = 7;
  localparam int TRIG_BIT = 7;
  localparam int BUSY_BIT = 7;
  localparam logic [3:0] RATE_RESET = 4'h9;
  localparam logic [2:0] AMOUNT_RESET = 3'h0;
  localparam logic [6:0] LENGTH_RESET = 7'h1b;
  localparam logic [2:0] AMOUNT_OFF = 3'h0;
  localparam int STORE_TIME_US = 10;
  localparam int CLK_MHZ = 100;
  localparam int STORE_CYCLES = STORE_TIME_US * CLK_MHZ;
  localparam logic [15:0] RATE_FACTOR_0 = 16'h1630;
  localparam logic [15:0] RATE_FACTOR_STEP = 16'h010c;
  localparam logic [15:0] RATE_FACTOR_9 = 16'h0cd6;
  localparam logic [15:0] RATE_FACTOR_10 = 16'h0bb8;
  typedef enum logic [1:0] {ST_IDLE, ST_STORE} store_state_t;
endpackage
`default_nettype wire

// File: spread_and_nvm_store_control.sv
// spread modulation settings, nonvolatile store trigger, lock and read length
// assumes an smbus slave front end presents single-cycle register strobes
//
// Function
// (RULE1) busy flag high during programming, then low
// (RULE2) host writes to busy flag ignored
// (RULE3) host sends no writes during store
// (RULE4) reads served while store runs
// (RULE5) rate code picks one of sixteen factors
// (RULE6) host bypasses pll before rate change
// (RULE7) amount code picks center or down spread
// (RULE8) host bypasses pll before amount change
// (RULE9) amount zero powers modulator down, output low
// (RULE10) lock acts only from stored copy, permanent
// (RULE11) locked: registers writable, stores refused
// (RULE12) length field sets block-read byte count
// (RULE13) store starts only on trigger rising edge
// (RULE14) trigger stays high until host clears it
// (RULE15) host writes trigger last, zero then one
// (RULE16) host never interrupts a running store
// (RULE17) edge found by comparing new and old value
`timescale 1ns/1ps
`default_nettype none
module spread_and_nvm_store_control
  import spread_nvm_pkg::*;
#(
  parameter int STORE_COUNT = STORE_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic NVM_LOCK_STORED,
  output logic [7:0] RDATA,
  output logic STORE_BUSY,
  output logic STORE_START,
  output logic NVM_LOCKED,
  output logic [3:0] RATE_SEL,
  output logic [15:0] RATE_FACTOR,
  output logic [2:0] AMOUNT_SEL,
  output logic SPREAD_PWR_DN,
  output logic SPREAD_OUT_EN,
  output logic [6:0] BLOCK_LEN
);
  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  logic [3:0] rate_q, rate_d;
  logic [2:0] amount_q, amount_d;
  logic lock_bit_q, lock_bit_d;
  logic [6:0] len_q, len_d;
  logic trig_q, trig_d;
  logic [7:0] rdata_q, rdata_d;
  logic locked_q, locked_d;
  logic [15:0] factor_q, factor_d;
  logic pd_q, pd_d;
  logic out_en_q, out_en_d;
  logic wr_spread, wr_store, rise;
  // sequencer state up front: the read mux shows the busy flag
  store_state_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] run_q, run_d;
  logic busy_q, busy_d, start_q, start_d;

  always_comb begin
    wr_spread = WR_EN && ADDR == SPREAD_LOCK_OFS;
    wr_store = WR_EN && ADDR == STORE_LEN_OFS;
    rate_d = rate_q;
    amount_d = amount_q;
    lock_bit_d = lock_bit_q;
    len_d = len_q;
    trig_d = trig_q;
    if (wr_spread) begin
      rate_d = WDATA[RATE_LSB+:4];
      amount_d = WDATA[AMOUNT_LSB+:3];
      lock_bit_d = WDATA[LOCK_BIT]; // RULE10
    end
    if (wr_store) begin
      // zero count not allowed: keep old value
      if (WDATA[6:0] != 7'h00) begin
        len_d = WDATA[6:0]; // RULE12
      end
      trig_d = WDATA[TRIG_BIT]; // RULE14
    end
    rise = wr_store && WDATA[TRIG_BIT] && !trig_q; // RULE13 RULE17
    // lock latches from the stored copy and never releases
    locked_d = locked_q || NVM_LOCK_STORED; // RULE10 RULE11
    pd_d = amount_d == AMOUNT_OFF; // RULE9
    out_en_d = !pd_d; // RULE9
    if (rate_d == 4'h9) begin
      factor_d = RATE_FACTOR_9; // RULE5
    end else if (rate_d == 4'ha) begin
      factor_d = RATE_FACTOR_10;
    end else if (rate_d < 4'h9) begin
      factor_d = 16'(RATE_FACTOR_0 - 16'(rate_d) * RATE_FACTOR_STEP);
    end else begin
      factor_d = 16'(RATE_FACTOR_10 - 16'(rate_d - 4'ha) * RATE_FACTOR_STEP);
    end
    rdata_d = rdata_q;
    if (RD_EN) begin
      // reads always answered, even mid-store
      case (ADDR)
        SPREAD_LOCK_OFS: rdata_d = {lock_bit_q, amount_q, rate_q}; // RULE4
        STORE_LEN_OFS: rdata_d = {trig_q, len_q};
        BUSY_OFS: rdata_d = {busy_q, 7'h00}; // RULE1
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // store sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    start_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (rise && !locked_q) begin
          st_d = ST_STORE; // RULE13 RULE11
          cnt_d = 32'(STORE_COUNT - 1);
          start_d = 1'b1;
        end
      end
      ST_STORE: begin
        if (cnt_q == 32'h0) begin
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 32'h1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // busy only follows the sequencer, never the bus data
    busy_d = st_d == ST_STORE; // RULE1 RULE2
    // length of the current busy stretch, for the duration check
    run_d = busy_q ? run_q + 32'h1 : 32'h0;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rate_q <= RATE_RESET;
      amount_q <= AMOUNT_RESET;
      lock_bit_q <= 1'b0;
      len_q <= LENGTH_RESET;
      trig_q <= 1'b0;
      rdata_q <= 8'h00;
      locked_q <= 1'b0;
      factor_q <= RATE_FACTOR_9;
      pd_q <= 1'b1;
      out_en_q <= 1'b0;
      st_q <= ST_IDLE;
      cnt_q <= 32'h0;
      run_q <= 32'h0;
      busy_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      rate_q <= rate_d;
      amount_q <= amount_d;
      lock_bit_q <= lock_bit_d;
      len_q <= len_d;
      trig_q <= trig_d;
      rdata_q <= rdata_d;
      locked_q <= locked_d;
      factor_q <= factor_d;
      pd_q <= pd_d;
      out_en_q <= out_en_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      busy_q <= busy_d;
      start_q <= start_d;
    end
  end

  assign RDATA = rdata_q;
  assign STORE_BUSY = busy_q;
  assign STORE_START = start_q;
  assign NVM_LOCKED = locked_q;
  assign RATE_SEL = rate_q;
  assign RATE_FACTOR = factor_q;
  assign AMOUNT_SEL = amount_q;
  assign SPREAD_PWR_DN = pd_q;
  assign SPREAD_OUT_EN = out_en_q;
  assign BLOCK_LEN = len_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  store_start_a: assert property (@(posedge CLK) disable iff (RST) // RULE13
    (rise && !locked_q && st_q == ST_IDLE) |=> STORE_START && STORE_BUSY)
    else $error("store did not start on trigger edge");
  no_level_a: assert property (@(posedge CLK) disable iff (RST) // RULE13
    (STORE_START |-> $past(WR_EN) && !$past(trig_q)))
    else $error("store started without a rising trigger");
  lock_refuse_a: assert property (@(posedge CLK) disable iff (RST) // RULE11
    locked_q |=> !STORE_START)
    else $error("store started while locked");
  lock_stays_a: assert property (@(posedge CLK) disable iff (RST) // RULE10
    locked_q |=> locked_q)
    else $error("lock released");
  lock_source_a: assert property (@(posedge CLK) disable iff (RST) // RULE10
    $rose(locked_q) |-> $past(NVM_LOCK_STORED))
    else $error("lock set without stored copy");
  trig_hold_a: assert property (@(posedge CLK) disable iff (RST) // RULE14
    (trig_q && !(WR_EN && ADDR == STORE_LEN_OFS)) |=> trig_q)
    else $error("trigger cleared without a write");
  busy_high_a: assert property (@(posedge CLK) disable iff (RST) // RULE1
    STORE_START |-> STORE_BUSY [*2])
    else $error("busy dropped early");
  busy_only_a: assert property (@(posedge CLK) disable iff (RST) // RULE2
    $rose(STORE_BUSY) |-> STORE_START)
    else $error("busy set without a store");
  spread_off_a: assert property (@(posedge CLK) disable iff (RST) // RULE9
    (AMOUNT_SEL == AMOUNT_OFF) |-> SPREAD_PWR_DN && !SPREAD_OUT_EN)
    else $error("modulator not powered down");
  len_nonzero_a: assert property (@(posedge CLK) disable iff (RST) // RULE12
    BLOCK_LEN != 7'h00)
    else $error("block length zero");
  read_busy_a: assert property (@(posedge CLK) disable iff (RST) // RULE4
    (RD_EN && ADDR == BUSY_OFS && busy_q) |=> RDATA[BUSY_BIT])
    else $error("busy read failed during store");
  spread_on_a: assert property (@(posedge CLK) disable iff (RST) // RULE9
    (AMOUNT_SEL != AMOUNT_OFF) |-> !SPREAD_PWR_DN && SPREAD_OUT_EN)
    else $error("modulator not running");
  busy_len_a: assert property (@(posedge CLK) disable iff (RST) // RULE1
    $fell(STORE_BUSY) |-> run_q == 32'(STORE_COUNT))
    else $error("store busy length wrong");
  len_keep_a: assert property (@(posedge CLK) disable iff (RST) // RULE12
    (WR_EN && ADDR == STORE_LEN_OFS && WDATA[6:0] == 7'h00) |=> $stable(BLOCK_LEN))
    else $error("zero block length taken");
endmodule
`default_nettype wire

// File: host_model.sv
// host stand-in driving the register strobes of the control bank
// assumes strobes are taken on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic busy,
  input wire logic [7:0] rdata,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    addr = ~a;
    d = rdata;
  endtask
  // pll bypass lives outside this bank, so 0x03 is unmapped here
  task automatic sp(input logic [7:0] d);
    wr(8'h03, 8'h40);
    wr(8'h19, d);
    wr(8'h03, 8'h00);
  endtask
  task automatic trig(input logic [6:0] len);
    wr(8'h1a, {1'b0, len});
    wr(8'h1a, {1'b1, len});
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the spread and store control bank
// assumes host_model as the register master
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SC = 8;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic lock_st = 1'b0;
  logic wr_en, rd_en, busy, start, locked, pwr_dn, out_en;
  logic [7:0] addr, wdata, rdata, rv;
  logic [3:0] rate_sel;
  logic [15:0] factor;
  logic [2:0] amt;
  logic [6:0] blen;
  int fail_count = 0;
  int checks = 0;
  int starts = 0;
  int busy_cyc = 0;
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    starts <= starts + int'(start === 1'b1);
    busy_cyc <= busy_cyc + int'(busy === 1'b1);
  end
  spread_and_nvm_store_control #(.STORE_COUNT(SC)) spread_and_nvm_store_control_i (
    .CLK(CLK), .RST(RST), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata),
    .NVM_LOCK_STORED(lock_st), .RDATA(rdata), .STORE_BUSY(busy), .STORE_START(start),
    .NVM_LOCKED(locked), .RATE_SEL(rate_sel), .RATE_FACTOR(factor), .AMOUNT_SEL(amt),
    .SPREAD_PWR_DN(pwr_dn), .SPREAD_OUT_EN(out_en), .BLOCK_LEN(blen));
  host_model host_model_i (.clk(CLK), .busy(busy), .rdata(rdata), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_model_i.rd(a, rv);
    chk(16'(rv), 16'(e));
  endtask
  task automatic t_reset;
    rchk(8'h19, 8'h09);
    rchk(8'h1a, 8'h1b);
    rchk(8'h18, 8'h00);
    chk(factor, 16'h0cd6);
    chk(16'({pwr_dn, out_en}), 16'h0002);
    $display("t_reset done");
  endtask
  task automatic t_codes;
    logic [15:0] f;
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      f = 16'h1630 - 16'h010c * 16'(i);
      if (i == 9)
        f = 16'h0cd6;
      if (i == 10)
        f = 16'h0bb8;
      host_model_i.sp({1'b0, c[2:0], c});
      chk(factor, f);
      chk({rate_sel, 1'b0, amt, 6'h00, pwr_dn, out_en},
          {c, 1'b0, c[2:0], 6'h00, c[2:0] == 3'h0, c[2:0] != 3'h0});
      rchk(8'h19, {1'b0, c[2:0], c});
    end
    $display("t_codes done");
  endtask
  task automatic t_len;
    host_model_i.wr(8'h1a, 8'h7f);
    chk(16'(blen), 16'h007f);
    host_model_i.wr(8'h1a, 8'h00);
    chk(16'(blen), 16'h007f);
    host_model_i.wr(8'h1a, 8'h01);
    rchk(8'h1a, 8'h01);
    $display("t_len done");
  endtask
  task automatic t_store;
    int s;
    int b;
    s = starts;
    b = busy_cyc;
    host_model_i.trig(7'h1b);
    rchk(8'h18, 8'h80);
    rchk(8'h1a, 8'h9b);
    repeat (SC) @(negedge CLK);
    chk(16'(busy_cyc - b), 16'(SC));
    chk(16'(starts - s), 16'h0001);
    host_model_i.wr(8'h18, 8'h80);
    rchk(8'h18, 8'h00);
    host_model_i.wr(8'h1a, 8'h9b);
    rchk(8'h1a, 8'h9b);
    chk(16'(starts - s), 16'h0001);
    $display("t_store done");
  endtask
  task automatic t_lock;
    int s;
    s = starts;
    host_model_i.sp(8'h89);
    host_model_i.trig(7'h1b);
    repeat (SC + 2) @(negedge CLK);
    chk(16'(starts - s), 16'h0001);
    chk(16'(locked), 16'h0000);
    lock_st = 1'b1;
    @(negedge CLK);
    lock_st = 1'b0;
    repeat (2) @(negedge CLK);
    chk(16'(locked), 16'h0001);
    host_model_i.trig(7'h1b);
    host_model_i.sp(8'h23);
    chk(16'(starts - s), 16'h0001);
    rchk(8'h18, 8'h00);
    chk(16'(rate_sel), 16'h0003);
    $display("t_lock done");
  endtask
  task automatic wrap_up;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge CLK);
    RST = 1'b0;
    t_reset;
    t_codes;
    t_len;
    t_store;
    t_lock;
    wrap_up;
  end
  initial begin
    #60000;
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
